// File: inc/hub_desc_params.svh
`ifndef HUB_DESC_PARAMS_SVH
`define HUB_DESC_PARAMS_SVH

// Descriptor lengths.
`define LEN_INTF 8'h09
`define LEN_EP 8'h07
`define LEN_DEV 8'h12
`define LEN_QUAL 8'h0A

// Descriptor type codes.
`define TYPE_DEV 8'h01
`define TYPE_INTF 8'h04
`define TYPE_EP 8'h05
`define TYPE_QUAL 8'h06

// Common field values.
`define VAL_00 8'h00
`define VAL_01 8'h01
`define VAL_02 8'h02
`define VAL_03 8'h03
`define HUB_CLASS 8'h09
`define USB_REL 16'h0200
`define EP0_MPS 8'h40
`define EP_ADDR 8'h81
`define EP_ATTR 8'h03
`define EP_MPS 16'h0001
`define EP_INTERVAL 8'h0C

`endif

// File: inc/hub_desc_pkg.sv
package hub_desc_pkg;
    // Selects which descriptor a read walks through.
    typedef enum logic [1:0] {
        SEL_INTF_MTT,
        SEL_EP_MTT,
        SEL_DEVICE,
        SEL_QUALIFIER
    } desc_sel_t;

    // Read sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_DONE
    } rd_state_t;
endpackage

// File: hdl/hub_descriptor_table.sv
// Operation
// - Multi-TT interface: length, type, numbers, one endpoint.
// - Multi-TT interface: hub class, protocol 02h, no string.
// - Multi-TT descriptors only when Multi-TT advertised.
// - Status endpoint: length, type, address 81h, interrupt.
// - Status endpoint packet size 0001h, interval 0Ch.
// - Device descriptor: length, type, release, 64-byte EP0.
// - Device descriptor: hub class, protocol 01h, one config.
// - Vendor, product, device IDs come from loader.
// - String indices zero or 1,2,3 per enable.
// - Qualifier: length, type, release, hub class, protocol.
// - Qualifier: 64-byte other-speed EP0, one config, reserved.
// - Interface protocol is fixed at 02h; no input changes it.
`timescale 1ns/1ns
`include "hub_desc_params.svh"

module hub_descriptor_table (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Loaded configuration.
    input wire logic [15:0] vendor_id_i,
    input wire logic [15:0] product_id_i,
    input wire logic [15:0] device_id_i,
    input wire logic string_en_i,
    input wire logic mtt_enable_i,
    // Descriptor request.
    input wire logic req_valid_i,
    input wire hub_desc_pkg::desc_sel_t req_sel_i,
    input wire logic [15:0] req_len_i,
    output logic req_ready_o,
    output logic req_stall_o,
    // Byte stream out.
    output logic [7:0] data_o,
    output logic data_valid_o,
    output logic data_last_o,
    input wire logic data_ready_i
);
    import hub_desc_pkg::*;

    // Two-byte constants are held as named words so their bytes can be sliced apart.
    // A sized literal from a macro cannot be part-selected directly.
    localparam logic [15:0] USB_REL_W = `USB_REL;
    localparam logic [15:0] EP_MPS_W = `EP_MPS;

    // Sequencer state and the request captured when it was taken.
    rd_state_t state_reg, state_next;
    desc_sel_t sel_reg, sel_next;
    logic [4:0] idx_reg, idx_next; // Offset of the byte now on data_o.
    logic [4:0] end_reg, end_next; // Offset of the last byte to send.
    logic [7:0] data_reg, data_next;
    logic stall_reg, stall_next; // One-cycle refusal pulse.

    // Full length of each descriptor.
    function automatic logic [7:0] desc_len(input desc_sel_t s);
        unique case (s)
            SEL_INTF_MTT: desc_len = `LEN_INTF;
            SEL_EP_MTT: desc_len = `LEN_EP;
            SEL_DEVICE: desc_len = `LEN_DEV;
            SEL_QUALIFIER: desc_len = `LEN_QUAL;
        endcase
    endfunction

    // Pick the string index when strings are enabled, else zero.
    function automatic logic [7:0] str_idx(input logic en, input logic [7:0] idx);
        str_idx = en ? idx : `VAL_00;
    endfunction

    // Byte at a given offset of a descriptor; two-byte fields go low byte first.
    function automatic logic [7:0] desc_byte(input desc_sel_t s, input logic [4:0] o,
                                             input logic [15:0] vid, input logic [15:0] pid,
                                             input logic [15:0] did, input logic sen);
        desc_byte = `VAL_00;
        unique case (s)
            SEL_INTF_MTT: begin
                case (o)
                    5'h00: desc_byte = `LEN_INTF;
                    5'h01: desc_byte = `TYPE_INTF;
                    5'h03: desc_byte = `VAL_01;
                    5'h04: desc_byte = `VAL_01;
                    5'h05: desc_byte = `HUB_CLASS;
                    // Protocol 02h marks the Multi-TT alternate setting.
                    5'h07: desc_byte = `VAL_02;
                    default: desc_byte = `VAL_00;
                endcase
            end
            SEL_EP_MTT: begin
                case (o)
                    5'h00: desc_byte = `LEN_EP;
                    5'h01: desc_byte = `TYPE_EP;
                    5'h02: desc_byte = `EP_ADDR;
                    5'h03: desc_byte = `EP_ATTR;
                    5'h04: desc_byte = EP_MPS_W[7:0];
                    5'h05: desc_byte = EP_MPS_W[15:8];
                    5'h06: desc_byte = `EP_INTERVAL;
                    default: desc_byte = `VAL_00;
                endcase
            end
            SEL_DEVICE: begin
                case (o)
                    5'h00: desc_byte = `LEN_DEV;
                    5'h01: desc_byte = `TYPE_DEV;
                    5'h02: desc_byte = USB_REL_W[7:0];
                    5'h03: desc_byte = USB_REL_W[15:8];
                    5'h04: desc_byte = `HUB_CLASS;
                    5'h06: desc_byte = `VAL_01;
                    5'h07: desc_byte = `EP0_MPS;
                    5'h08: desc_byte = vid[7:0];
                    5'h09: desc_byte = vid[15:8];
                    5'h0A: desc_byte = pid[7:0];
                    5'h0B: desc_byte = pid[15:8];
                    5'h0C: desc_byte = did[7:0];
                    5'h0D: desc_byte = did[15:8];
                    5'h0E: desc_byte = str_idx(sen, `VAL_01);
                    5'h0F: desc_byte = str_idx(sen, `VAL_02);
                    5'h10: desc_byte = str_idx(sen, `VAL_03);
                    5'h11: desc_byte = `VAL_01;
                    default: desc_byte = `VAL_00;
                endcase
            end
            SEL_QUALIFIER: begin
                case (o)
                    5'h00: desc_byte = `LEN_QUAL;
                    5'h01: desc_byte = `TYPE_QUAL;
                    5'h02: desc_byte = USB_REL_W[7:0];
                    5'h03: desc_byte = USB_REL_W[15:8];
                    5'h04: desc_byte = `HUB_CLASS;
                    5'h07: desc_byte = `EP0_MPS;
                    5'h08: desc_byte = `VAL_01;
                    default: desc_byte = `VAL_00;
                endcase
            end
        endcase
    endfunction

    // Accept a request only while idle; the host waits for ready.
    // Ready and valid are decoded from the state register, stall comes from its own register; the byte itself is registered.
    assign req_ready_o = (state_reg == ST_IDLE);
    assign req_stall_o = stall_reg;
    assign data_o = data_reg;
    assign data_valid_o = (state_reg == ST_SEND);
    assign data_last_o = (state_reg == ST_SEND) && (idx_reg == end_reg);

    // Next-state logic of the sequencer.
    always_comb begin
        logic [15:0] full_len;
        logic [15:0] use_len;
        logic [4:0] nidx;
        full_len = 16'h0000;
        use_len = 16'h0000;
        nidx = 5'h00;
        state_next = state_reg;
        sel_next = sel_reg;
        idx_next = idx_reg;
        end_next = end_reg;
        data_next = data_reg;
        stall_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (req_valid_i) begin
                    full_len = {8'h00, desc_len(req_sel_i)};
                    // Shortest of the requested and the full length.
                    use_len = (req_len_i < full_len) ? req_len_i : full_len;
                    // Multi-TT descriptors are refused unless advertised.
                    if ((!mtt_enable_i && (req_sel_i == SEL_INTF_MTT ||
                                           req_sel_i == SEL_EP_MTT)) ||
                        use_len == 16'h0000) begin
                        // The refusal shows for one cycle and the table stays idle.
                        stall_next = 1'b1;
                    end else begin
                        state_next = ST_SEND;
                        sel_next = req_sel_i;
                        idx_next = 5'h00;
                        end_next = 5'(use_len - 16'h0001);
                        data_next = desc_byte(req_sel_i, 5'h00, vendor_id_i,
                                              product_id_i, device_id_i, string_en_i);
                    end
                end
            end
            ST_SEND: begin
                // Advance only when the consumer takes the byte.
                if (data_ready_i) begin
                    if (idx_reg == end_reg) begin
                        state_next = ST_DONE;
                    end else begin
                        // Fetch the next byte now so that it stands from the next edge.
                        nidx = idx_reg + 5'h01;
                        idx_next = nidx;
                        data_next = desc_byte(sel_reg, nidx, vendor_id_i,
                                              product_id_i, device_id_i, string_en_i);
                    end
                end
            end
            ST_DONE: begin
                // One idle cycle between transfers keeps the handshake simple.
                state_next = ST_IDLE;
            end
            default: begin
                // The unused state code falls back to idle rather than locking up.
                // Captured request fields are left as they are; the next take overwrites them.
                state_next = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            sel_reg <= SEL_INTF_MTT;
            idx_reg <= 5'h00;
            end_reg <= 5'h00;
            data_reg <= 8'h00;
            stall_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sel_reg <= sel_next;
            idx_reg <= idx_next;
            end_reg <= end_next;
            data_reg <= data_next;
            stall_reg <= stall_next;
        end
    end
endmodule

// File: testbench/hub_descriptor_table_chk.sv
`timescale 1ns/1ns
// Watches the request and byte-stream pins; most relations are timed from the take edge.
module hub_descriptor_table_chk
    import hub_desc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic mtt_enable_i,
    input wire logic req_valid_i,
    input wire desc_sel_t req_sel_i,
    input wire logic [15:0] req_len_i,
    input wire logic req_ready_o,
    input wire logic req_stall_o,
    input wire logic [7:0] data_o,
    input wire logic data_valid_o,
    input wire logic data_last_o,
    input wire logic data_ready_i
);
    // A take is a request seen while the table is idle.
    wire logic take = req_valid_i && req_ready_o;
    // Multi-TT tables exist only while the capability is advertised.
    wire logic no_mtt = !mtt_enable_i && (req_sel_i == SEL_INTF_MTT || req_sel_i == SEL_EP_MTT);
    // A refused take must stall and never stream.
    wire logic go = take && !no_mtt && req_len_i != 16'h0000;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    mtt_refuse_a: assert property (take && no_mtt |=> req_stall_o && !data_valid_o)
        else $error("Multi-TT read was not refused");
    zero_len_a: assert property (take && req_len_i == 16'h0000 |=> req_stall_o ##1 !req_stall_o)
        else $error("Empty read gave no single stall pulse");
    intf_first_a: assert property (go && req_sel_i == SEL_INTF_MTT |=> data_o == 8'h09)
        else $error("Interface table opens wrongly");
    ep_first_a: assert property (go && req_sel_i == SEL_EP_MTT |=> data_valid_o && data_o == 8'h07)
        else $error("Endpoint table opens wrongly");
    dev_first_a: assert property (go && req_sel_i == SEL_DEVICE |=> data_o == 8'h12)
        else $error("Device table opens wrongly");
    qual_first_a: assert property (go && req_sel_i == SEL_QUALIFIER |=> data_o == 8'h0A)
        else $error("Qualifier table opens wrongly");
    byte_hold_a: assert property (data_valid_o && !data_ready_i |=> data_valid_o && $stable(data_o))
        else $error("Byte changed while the host stalled");
    one_byte_a: assert property (go && req_len_i == 16'h0001 |=> data_last_o)
        else $error("One-byte read not marked last");
    busy_stream_a: assert property (data_valid_o |-> !req_ready_o && !req_stall_o)
        else $error("Idle or stall shown while streaming");
endmodule

bind hub_descriptor_table hub_descriptor_table_chk u_chk (.clk_i, .reset_n_i, .mtt_enable_i,
    .req_valid_i, .req_sel_i, .req_len_i, .req_ready_o, .req_stall_o, .data_o, .data_valid_o,
    .data_last_o, .data_ready_i);

// File: testbench/host_sink.sv
`timescale 1ns/1ns
// Host side of the byte stream; it records each byte it accepts.
module host_sink (
    // Clock and pace.
    input wire logic clk_i,
    input wire logic slow_i,
    // Byte stream from the table.
    input wire logic [7:0] data_o,
    input wire logic data_valid_o,
    input wire logic data_last_o,
    output logic data_ready_i
);
    logic [7:0] got[$];
    logic seen_last;
    logic [1:0] phase = 2'h0;
    // A slow host refuses two cycles in three, so held bytes are exercised.
    always @(negedge clk_i) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        data_ready_i <= !slow_i || phase == 2'h2;
    end
    // A byte counts only at a rising edge where both sides agree.
    always @(posedge clk_i) begin
        if (data_valid_o && data_ready_i) begin
            got.push_back(data_o);
            seen_last <= data_last_o;
        end
    end
endmodule

// File: testbench/hub_descriptor_table_tb_top.sv
`timescale 1ns/1ns
// Reads every table through the request port and compares the bytes with the expected layout.
module hub_descriptor_table_tb_top;
    import hub_desc_pkg::*;
    logic clk_i = 1'b0, reset_n_i = 1'b0, string_en_i = 1'b0, mtt_enable_i = 1'b1;
    logic req_valid_i = 1'b0, slow = 1'b0;
    logic [15:0] vendor_id_i = 16'h1234, product_id_i = 16'h5678, device_id_i = 16'h9ABC;
    desc_sel_t req_sel_i = SEL_DEVICE;
    logic [15:0] req_len_i = 16'h0040;
    logic req_ready_o, req_stall_o, data_valid_o, data_last_o, data_ready_i;
    logic [7:0] data_o;
    logic [7:0] exp[$];
    int bad_count = 0, samples_checked = 0, cycles = 0;
    always #20 clk_i = ~clk_i;
    hub_descriptor_table u_dut (.clk_i, .reset_n_i, .vendor_id_i, .product_id_i, .device_id_i,
        .string_en_i, .mtt_enable_i, .req_valid_i, .req_sel_i, .req_len_i, .req_ready_o,
        .req_stall_o, .data_o, .data_valid_o, .data_last_o, .data_ready_i);
    host_sink u_host (.clk_i, .slow_i(slow), .data_o, .data_valid_o, .data_last_o, .data_ready_i);
    task check(input logic [15:0] got, input logic [15:0] want);
        samples_checked++;
        if (got !== want) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // One request; the stream is then compared byte for byte with exp.
    task fetch(input desc_sel_t sel, input logic [15:0] len, input logic want_stall);
        @(negedge clk_i);
        u_host.got.delete();
        u_host.seen_last = 1'b0;
        req_sel_i = sel;
        req_len_i = len;
        req_valid_i = 1'b1;
        // Ready moves only on a rising edge; here it shows what the next take sees.
        while (req_ready_o !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        req_valid_i = 1'b0;
        check({15'h0000, req_stall_o}, {15'h0000, want_stall});
        while (exp.size() != 0 && u_host.seen_last !== 1'b1) @(negedge clk_i);
        check(16'(u_host.got.size()), 16'(exp.size()));
        foreach (exp[i]) check({8'h00, u_host.got[i]}, {8'h00, exp[i]});
        // Let the done cycle pass so the next take sees an idle table.
        repeat (2) @(negedge clk_i);
    endtask
    task t_mtt;
        exp = '{8'h09, 8'h04, 8'h00, 8'h01, 8'h01, 8'h09, 8'h00, 8'h02, 8'h00};
        fetch(SEL_INTF_MTT, 16'h0040, 1'b0);
        slow = 1'b1;
        exp = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C};
        fetch(SEL_EP_MTT, 16'h0040, 1'b0);
        slow = 1'b0;
        $display("Multi-TT tables done");
    endtask
    task t_dev;
        mtt_enable_i = 1'b0;
        exp = '{8'h12, 8'h01, 8'h00, 8'h02, 8'h09, 8'h00, 8'h01, 8'h40, 8'h34, 8'h12,
                8'h78, 8'h56, 8'hBC, 8'h9A, 8'h00, 8'h00, 8'h00, 8'h01};
        fetch(SEL_DEVICE, 16'h0040, 1'b0);
        // Strings on, and one byte short so the tail is cut off.
        string_en_i = 1'b1;
        exp[14] = 8'h01;
        exp[15] = 8'h02;
        exp[16] = 8'h03;
        void'(exp.pop_back());
        fetch(SEL_DEVICE, 16'h0011, 1'b0);
        $display("Device table done");
    endtask
    task t_qual;
        exp = '{8'h0A, 8'h06, 8'h00, 8'h02, 8'h09, 8'h00, 8'h00, 8'h40, 8'h01, 8'h00};
        fetch(SEL_QUALIFIER, 16'h00FF, 1'b0);
        exp = '{8'h0A};
        fetch(SEL_QUALIFIER, 16'h0001, 1'b0);
        $display("Qualifier table done");
    endtask
    task t_refuse;
        exp = {};
        fetch(SEL_INTF_MTT, 16'h0040, 1'b1);
        fetch(SEL_EP_MTT, 16'h0040, 1'b1);
        mtt_enable_i = 1'b1;
        fetch(SEL_DEVICE, 16'h0000, 1'b1);
        $display("Refusals done");
    endtask
    task close_out;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A hang is cut short well past the hundred or so cycles the tests need.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        reset_n_i = 1'b1;
        t_mtt();
        t_dev();
        t_refuse();
        t_qual();
        close_out();
    end
endmodule
